// [src/ecm_pkg.sv]
/*
 * Shared constants and types for the encoder command and memory block.
 * Assumes one 50 MHz core clock; all storage counts are fixed here.
 */
package ecm_pkg;
	// word and position widths
	localparam int CFG_W = 16;
	localparam int POS_W = 20;
	localparam int BIN_W = 4;
	// raw sample capture
	localparam int CAP_IDX_W = 10;
	localparam logic [9:0] CAP_SETS = 10'h320;
	// paged byte space
	localparam int PAGE_W = 3;
	localparam int BADDR_W = 7;
	localparam logic [6:0] PAGE_SEL_ADDR = 7'h7F;
	localparam logic [2:0] VALID_PAGE = 3'h7;
	localparam logic [6:0] VALID_MODE_ADDR = 7'h0A;
	// configuration word map
	localparam logic [7:0] CFG_COEF_LO = 8'h12;
	localparam logic [7:0] CFG_COEF_HI = 8'h21;
	localparam logic [7:0] CFG_BIN_LO = 8'h80;
	localparam logic [7:0] CFG_BIN_HI = 8'h8F;
	localparam logic [7:0] CFG_WAKE = 8'h90;
	localparam int CFG_WORDS = 33;
	localparam logic [5:0] SLOT_BIN0 = 6'h10;
	localparam logic [5:0] SLOT_WAKE = 6'h20;
	localparam logic [5:0] SLOT_NONE = 6'h3F;
	localparam logic [15:0] COEF_DEFAULT = 16'h0000;
	localparam logic [15:0] BIN_DEFAULT = 16'h0000;
	localparam logic [15:0] WAKE_DEFAULT = 16'h0015;
	// timing
	localparam int CLK_HZ = 50000000;
	localparam int MS_PER_S = 1000;
	localparam int FAST_WAKE_MS = 3;
	// reply path
	localparam int RSP_DEPTH = 8;
	localparam int RSP_MAX = 3;
	localparam logic [15:0] ACK_OK = 16'h0001;
	localparam logic [15:0] ACK_REFUSED = 16'h0000;
	// identity words, arbitrary values
	localparam logic [15:0] ENC_TYPE = 16'h0001;
	localparam logic [15:0] FW_VERSION = 16'h0100;

	typedef enum logic [2:0] {
		CMD_CAPTURE = 3'h0,
		CMD_FETCH = 3'h1,
		CMD_INFO = 3'h2,
		CMD_STORE_BYTE = 3'h3,
		CMD_LOAD_BYTE = 3'h4,
		CMD_STORE_WORD = 3'h5,
		CMD_LOAD_WORD = 3'h6
	} ecm_cmd_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_REPLY = 1'b1
	} ecm_state_t;
endpackage

// [src/ecm_fifo.sv]
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module ecm_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////
	// honest flags straight from the occupancy count
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage needs no reset, the count guards it
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers wrap by hand since depth need not be a power of two
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [src/ecm_core.sv]
/*
 * Command interpreter and user memory of the rotary encoder: capture
 * and readback, build info, paged byte store, configuration words,
 * bin correction of position and battery-mode wake scheduling.
 * Assumes a framer on CORE_CLK that delivers decoded commands and
 * serialises reply words, both bit 0 first, and a front-end bus
 * already retimed onto CORE_CLK.
 */
// Behaviour
// - capture command stores 800 front-end sample sets for later readback.
// - capture runs only when validation byte at page 7 address 0x0A is set.
// - fetch returns exactly the indexed set and echoes the index first.
// - coefficient words 0x12 to 0x21 take effect and persist; here they are only stored and read back, no logic uses them.
// - build info reply gives encoder type, firmware version, trim code.
// - byte space and word space reached by separate command pairs.
// - eight pages of 127 bytes; writing address 127 selects the page.
// - page 0 selected after every reset.
// - byte addresses travel least significant bit first.
// - bytes 0 to 126 on pages 0 to 5 are free persistent storage.
// - word contents travel least significant bit first both ways.
// - main supply below backup gives battery mode, link shut off.
// - in battery mode with motion, wake every 3 ms.
// - idle wake period from word 0x90, default 21.
// - idle period while still, 3 ms period while moving.
// - add the current bin correction word to each output position.
// - sixteen 22.5 degree bins, bin 0 uses word 0x80.
// - zero correction words leave the position unchanged.
// - words load from storage at start, writes saved back.
// - front-end data arrives over a 16-bit parallel bus.
`timescale 1ns/1ps
module ecm_core #(
	parameter int MS_CYCLES = 50000
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic LOAD_DEFAULTS,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire ecm_pkg::ecm_cmd_t CMD_CODE,
	input wire logic [7:0] CMD_ADDR,
	input wire logic [ecm_pkg::CFG_W-1:0] CMD_DATA,
	output logic RSP_VALID,
	input wire logic RSP_READY,
	output logic [ecm_pkg::CFG_W-1:0] RSP_DATA,
	input wire logic FE_VALID,
	input wire logic [ecm_pkg::CFG_W-1:0] FE_DATA,
	input wire logic [ecm_pkg::CFG_W-1:0] TRIM_CODE,
	input wire logic POS_VALID,
	input wire logic [ecm_pkg::POS_W-1:0] POS_IN,
	output logic POS_OUT_VALID,
	output logic [ecm_pkg::POS_W-1:0] POS_OUT,
	input wire logic MAIN_LOW,
	input wire logic MOTION,
	output logic BATTERY_MODE,
	output logic WAKE,
	output logic CAPTURE_BUSY
);
	import ecm_pkg::*;

	localparam int FAST_WAKE_CYCLES = FAST_WAKE_MS * MS_CYCLES;

	// map a configuration address onto a storage slot
	function automatic logic [5:0] cfg_slot(input logic [7:0] a);
		logic [7:0] d;
		d = '0;
		if (a >= CFG_COEF_LO && a <= CFG_COEF_HI) begin
			d = a - CFG_COEF_LO;
			return d[5:0];
		end else if (a >= CFG_BIN_LO && a <= CFG_BIN_HI) begin
			d = a - CFG_BIN_LO;
			return SLOT_BIN0 + d[5:0];
		end else if (a == CFG_WAKE) begin
			return SLOT_WAKE;
		end
		return SLOT_NONE;
	endfunction

	// sign-extend a correction word to position width
	function automatic logic [POS_W-1:0] sext(input logic [CFG_W-1:0] w);
		return {{(POS_W-CFG_W){w[CFG_W-1]}}, w};
	endfunction

	logic [CFG_W-1:0] cap_mem [2**CAP_IDX_W];
	logic [7:0] byte_mem [2**(PAGE_W+BADDR_W)];
	logic [CFG_W-1:0] cfg [CFG_WORDS];
	logic [PAGE_W-1:0] page;
	logic [CAP_IDX_W-1:0] cap_cnt;
	logic cap_busy;
	ecm_state_t state;
	logic [CFG_W-1:0] rsp_buf [RSP_MAX];
	logic [1:0] rsp_len;
	logic [1:0] rsp_pos;
	logic fifo_in_ready;
	logic main_low_s1;
	logic main_low_s2;
	logic motion_s1;
	logic motion_s2;
	logic batt_mode;
	logic [31:0] wake_cnt;
	logic [31:0] wake_period;
	logic accept;
	logic val_mode;
	logic [5:0] slot;
	logic [PAGE_W+BADDR_W-1:0] baddr;

	////////////////////////////////////////////////////////////////
	// pin synchronisers: both pins come from the supply and motion
	// detectors, not from this clock
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			main_low_s1 <= 1'b0;
			main_low_s2 <= 1'b0;
			motion_s1 <= 1'b0;
			motion_s2 <= 1'b0;
		end else begin
			main_low_s1 <= MAIN_LOW;
			main_low_s2 <= main_low_s1;
			motion_s1 <= MOTION;
			motion_s2 <= motion_s1;
		end
	end

	// battery mode follows the supply comparison
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			batt_mode <= 1'b0;
		end else begin
			batt_mode <= main_low_s2;
		end
	end
	assign BATTERY_MODE = batt_mode;

	////////////////////////////////////////////////////////////////
	// command acceptance; the link is dead in battery mode
	assign CMD_READY = (state == ST_IDLE) && !batt_mode;
	assign accept = CMD_VALID && CMD_READY;
	assign slot = cfg_slot(CMD_ADDR);
	// address bit 0 is the first bit the framer received
	assign baddr = {page, CMD_ADDR[BADDR_W-1:0]};
	assign val_mode = (byte_mem[{VALID_PAGE, VALID_MODE_ADDR}] != 8'h00);

	// page register is control state, so reset always returns page 0
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			page <= '0;
		end else if (accept && CMD_CODE == CMD_STORE_BYTE
				&& CMD_ADDR[BADDR_W-1:0] == PAGE_SEL_ADDR) begin
			page <= CMD_DATA[PAGE_W-1:0];
		end
	end

	// byte space has no reset so it survives power cycles
	always_ff @(posedge CORE_CLK) begin
		if (accept && CMD_CODE == CMD_STORE_BYTE
				&& CMD_ADDR[BADDR_W-1:0] != PAGE_SEL_ADDR) begin
			byte_mem[baddr] <= CMD_DATA[7:0];
		end
	end

	// word space is the persistent copy itself, so the start-up load
	// is implicit; defaults need an explicit factory load
	always_ff @(posedge CORE_CLK) begin
		if (LOAD_DEFAULTS) begin
			for (int i = 0; i < CFG_WORDS; i++) begin
				cfg[i] <= (i < int'(SLOT_BIN0)) ? COEF_DEFAULT : BIN_DEFAULT;
			end
			cfg[SLOT_WAKE] <= WAKE_DEFAULT;
		end else if (accept && CMD_CODE == CMD_STORE_WORD && slot != SLOT_NONE) begin
			cfg[slot] <= CMD_DATA;
		end
	end

	////////////////////////////////////////////////////////////////
	// sample capture from the front-end parallel bus
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			cap_busy <= 1'b0;
			cap_cnt <= '0;
		end else if (cap_busy) begin
			if (FE_VALID) begin
				cap_cnt <= cap_cnt + 1'b1;
				if (cap_cnt == CAP_SETS - 1'b1) begin
					cap_busy <= 1'b0;
				end
			end
		end else if (accept && CMD_CODE == CMD_CAPTURE && val_mode) begin
			cap_busy <= 1'b1;
			cap_cnt <= '0;
		end
	end
	assign CAPTURE_BUSY = cap_busy;

	// captured sets are held for readback until the next capture
	always_ff @(posedge CORE_CLK) begin
		if (cap_busy && FE_VALID) begin
			cap_mem[cap_cnt] <= FE_DATA;
		end
	end

	////////////////////////////////////////////////////////////////
	// reply builder: words are formed at acceptance so that a later
	// write cannot alter a reply already owed
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			state <= ST_IDLE;
			rsp_len <= '0;
			rsp_pos <= '0;
			for (int i = 0; i < RSP_MAX; i++) begin
				rsp_buf[i] <= '0;
			end
		end else begin
			case (state)
			ST_IDLE: begin
				if (accept) begin
					state <= ST_REPLY;
					rsp_pos <= '0;
					rsp_len <= 2'h1;
					rsp_buf[0] <= ACK_OK;
					rsp_buf[1] <= '0;
					rsp_buf[2] <= '0;
					case (CMD_CODE)
					CMD_CAPTURE: begin
						rsp_buf[0] <= (val_mode && !cap_busy) ? ACK_OK : ACK_REFUSED;
					end
					CMD_FETCH: begin
						rsp_len <= 2'h2;
						rsp_buf[0] <= {6'h00, CMD_DATA[CAP_IDX_W-1:0]};
						rsp_buf[1] <= cap_mem[CMD_DATA[CAP_IDX_W-1:0]];
					end
					CMD_INFO: begin
						rsp_len <= 2'h3;
						rsp_buf[0] <= ENC_TYPE;
						rsp_buf[1] <= FW_VERSION;
						rsp_buf[2] <= TRIM_CODE;
					end
					CMD_LOAD_BYTE: begin
						if (CMD_ADDR[BADDR_W-1:0] == PAGE_SEL_ADDR) begin
							rsp_buf[0] <= {13'h0000, page};
						end else begin
							rsp_buf[0] <= {8'h00, byte_mem[baddr]};
						end
					end
					CMD_LOAD_WORD: begin
						rsp_buf[0] <= (slot == SLOT_NONE) ? '0 : cfg[slot];
					end
					default: begin
						rsp_buf[0] <= ACK_OK;
					end
					endcase
				end
			end
			ST_REPLY: begin
				// the fifo stalls the builder when the framer is slow
				if (fifo_in_ready) begin
					rsp_pos <= rsp_pos + 1'b1;
					if (rsp_pos == rsp_len - 1'b1) begin
						state <= ST_IDLE;
					end
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	ecm_fifo #(
		.WIDTH(CFG_W),
		.DEPTH(RSP_DEPTH)
	) u_rsp_fifo (
		.clk(CORE_CLK),
		.resetn(RESETN),
		.in_valid(state == ST_REPLY),
		.in_ready(fifo_in_ready),
		.in_data(rsp_buf[rsp_pos]),
		.out_valid(RSP_VALID),
		.out_ready(RSP_READY),
		.out_data(RSP_DATA)
	);

	////////////////////////////////////////////////////////////////
	// bin correction: top four position bits give the 22.5 degree bin
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			POS_OUT_VALID <= 1'b0;
			POS_OUT <= '0;
		end else begin
			POS_OUT_VALID <= POS_VALID;
			if (POS_VALID) begin
				// truncation is the modulo wrap of one revolution
				POS_OUT <= POS_W'(POS_IN + sext(cfg[SLOT_BIN0 + POS_IN[POS_W-1 -: BIN_W]]));
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// wake scheduler; period is re-evaluated every cycle so a motion
	// change takes hold within the current interval
	always_comb begin
		if (motion_s2) begin
			wake_period = 32'(FAST_WAKE_CYCLES);
		end else begin
			wake_period = 32'(cfg[SLOT_WAKE] * MS_CYCLES);
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			wake_cnt <= '0;
			WAKE <= 1'b0;
		end else if (!batt_mode) begin
			wake_cnt <= '0;
			WAKE <= 1'b0;
		end else if (wake_cnt + 1'b1 >= wake_period) begin // a zero period wakes every cycle instead of never
			wake_cnt <= '0;
			WAKE <= 1'b1;
		end else begin
			wake_cnt <= wake_cnt + 1'b1;
			WAKE <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	property p_link_off;
		batt_mode |-> !CMD_READY;
	endproperty
	a_link_off: assert property (p_link_off) else $error("command taken in battery mode");

	property p_cap_gate;
		accept && CMD_CODE == CMD_CAPTURE && !val_mode && !cap_busy |=> !cap_busy;
	endproperty
	a_cap_gate: assert property (p_cap_gate) else $error("capture outside validation mode");

	property p_cap_end;
		cap_busy && FE_VALID && cap_cnt == CAP_SETS - 1'b1 |=> !cap_busy && cap_cnt == CAP_SETS;
	endproperty
	a_cap_end: assert property (p_cap_end) else $error("capture length wrong");

	property p_page_reset;
		$rose(RESETN) |-> page == '0;
	endproperty
	a_page_reset: assert property (p_page_reset) else $error("page not 0 after reset");

	property p_page_sel;
		accept && CMD_CODE == CMD_STORE_BYTE && CMD_ADDR[6:0] == PAGE_SEL_ADDR
			|=> page == $past(CMD_DATA[PAGE_W-1:0]);
	endproperty
	a_page_sel: assert property (p_page_sel) else $error("page select lost");

	property p_fetch_echo;
		accept && CMD_CODE == CMD_FETCH |=> rsp_buf[0][CAP_IDX_W-1:0] == $past(CMD_DATA[CAP_IDX_W-1:0]) && rsp_len == 2'h2;
	endproperty
	a_fetch_echo: assert property (p_fetch_echo) else $error("fetch index not echoed");

	property p_info;
		accept && CMD_CODE == CMD_INFO |=> rsp_buf[2] == $past(TRIM_CODE) && rsp_buf[1] == FW_VERSION;
	endproperty
	a_info: assert property (p_info) else $error("build info wrong");

	property p_word_save;
		accept && CMD_CODE == CMD_STORE_WORD && slot != SLOT_NONE && !LOAD_DEFAULTS
			|=> cfg[$past(slot)] == $past(CMD_DATA);
	endproperty
	a_word_save: assert property (p_word_save) else $error("word write not saved");

	property p_pos_zero;
		POS_VALID && cfg[SLOT_BIN0 + POS_IN[POS_W-1 -: BIN_W]] == '0 |=> POS_OUT == $past(POS_IN);
	endproperty
	a_pos_zero: assert property (p_pos_zero) else $error("zero correction moved position");

	property p_wake_batt;
		WAKE |-> $past(batt_mode) && wake_cnt == '0;
	endproperty
	a_wake_batt: assert property (p_wake_batt) else $error("wake outside battery mode");

	c_capture: cover property (cap_busy ##1 !cap_busy);
	c_fetch: cover property (accept && CMD_CODE == CMD_FETCH);
	c_page: cover property (accept && CMD_CODE == CMD_STORE_BYTE && CMD_ADDR[6:0] == PAGE_SEL_ADDR);
	c_wake: cover property (WAKE);
endmodule

// [verif/ecm_master_model.sv]
/*
 * Far-side model: collects reply words with an optional stall and acts as
 * the front end, strobing numbered samples while a capture runs.
 * Assumes the bench drives stall just after a rising edge.
 */
`timescale 1ns/1ps
module ecm_master_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	output logic rsp_ready,
	input wire logic capture_busy,
	output logic fe_valid,
	output logic [15:0] fe_data
);
	logic [15:0] q[$];
	logic [9:0] n_sent;

	// a stall holds the reply stream so the buffer can fill
	assign rsp_ready = !stall;

	// reply words arrive whole, the framer already sent bit 0 first
	always @(posedge clk) begin
		if (rsp_valid && rsp_ready) q.push_back(rsp_data);
	end

	// sample k carries a pattern of k; between strobes the bus shows the inverse, never a stale value
	always @(posedge clk) begin
		if (!rst_n) begin
			fe_valid <= 1'b0;
			n_sent <= 10'h000;
			fe_data <= 16'hFFFF;
		end else if (capture_busy && !fe_valid) begin
			fe_valid <= 1'b1;
			fe_data <= {6'h00, n_sent} ^ 16'hA5A5;
		end else begin
			fe_valid <= 1'b0;
			fe_data <= ~fe_data;
			if (fe_valid && capture_busy) n_sent <= n_sent + 10'h001;
		end
	end
endmodule

// [verif/encoder_command_memory_bench.sv]
/*
 * Self-checking bench for the encoder command and memory core.
 * Assumes the package, FIFO, core and master model are compiled first.
 */
`timescale 1ns/1ps
module encoder_command_memory_bench;
	import ecm_pkg::*;
	localparam int MSC = 10;
	logic clk, rst_n, load_def, cmd_valid, cmd_ready, rsp_valid, rsp_ready, stall;
	logic fe_valid, pos_valid, pos_out_valid, main_low, motion, batt, wake, busy;
	ecm_cmd_t cmd_code;
	logic [7:0] cmd_addr;
	logic [15:0] cmd_data, rsp_data, fe_data, trim;
	logic [19:0] pos_in, pos_out;
	int n_mismatch, comparisons;
	longint corr;

	ecm_core #(.MS_CYCLES(MSC)) u_ecm_core (.CORE_CLK(clk), .RESETN(rst_n), .LOAD_DEFAULTS(load_def),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_CODE(cmd_code), .CMD_ADDR(cmd_addr),
		.CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .RSP_DATA(rsp_data),
		.FE_VALID(fe_valid), .FE_DATA(fe_data), .TRIM_CODE(trim), .POS_VALID(pos_valid), .POS_IN(pos_in),
		.POS_OUT_VALID(pos_out_valid), .POS_OUT(pos_out), .MAIN_LOW(main_low), .MOTION(motion),
		.BATTERY_MODE(batt), .WAKE(wake), .CAPTURE_BUSY(busy));
	ecm_master_model u_ecm_master_model (.clk(clk), .rst_n(rst_n), .stall(stall), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_ready(rsp_ready), .capture_busy(busy), .fe_valid(fe_valid), .fe_data(fe_data));

	////////////////////////////////////////////////////////////////////////////
	// 50 MHz core clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// inputs move 1 ns after the edge so nothing races the sampling edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ready is sampled at the falling edge, where it is settled before the accepting edge
	task automatic cmd(input ecm_cmd_t c, input logic [7:0] a, input logic [15:0] d);
		logic ok;
		int t;
		cmd_code = c;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		t = 0;
		do begin
			@(negedge clk) ok = cmd_ready;
			@(posedge clk);
			t++;
		end while (ok !== 1'b1 && t < 50);
		#1 cmd_valid = 1'b0;
		if (ok !== 1'b1) chk("command taken", 20'h1, 20'h0);
	endtask

	task automatic rsp(input string what, input logic [15:0] exp);
		int t;
		t = 0;
		while (u_ecm_master_model.q.size() == 0 && t < 200) begin
			cyc(1);
			t++;
		end
		if (u_ecm_master_model.q.size() == 0) chk(what, 20'(exp), 20'hFFFFF);
		else chk(what, 20'(exp), 20'(u_ecm_master_model.q.pop_front()));
	endtask

	// every store is acknowledged, then the master keeps its quiet time
	task automatic st(input ecm_cmd_t c, input logic [7:0] a, input logic [15:0] d);
		cmd(c, a, d);
		rsp("store ack", ACK_OK);
		cyc(15 * MSC);
	endtask

	task automatic ld(input ecm_cmd_t c, input logic [7:0] a, input logic [15:0] exp);
		cmd(c, a, 16'h0000);
		rsp("load reply", exp);
	endtask

	task automatic pos(input logic [19:0] p, input logic [19:0] exp);
		pos_in = p;
		pos_valid = 1'b1;
		cyc(1);
		chk("position valid", 20'h1, 20'(pos_out_valid));
		chk("position", exp, pos_out);
	endtask

	// skips two intervals so a change of period has settled, then measures the next
	task automatic gap(input string what, input int exp);
		int t;
		repeat (2) begin
			t = 0;
			do begin
				cyc(1);
				t++;
			end while (wake !== 1'b1 && t < 1000);
		end
		t = 0;
		do begin
			cyc(1);
			t++;
		end while (wake !== 1'b1 && t < 1000);
		chk(what, 20'(exp), 20'(t));
	endtask

	task automatic test_done();
		if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// watchdog, well beyond the few thousand cycles the sequence needs
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		test_done();
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		load_def = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = CMD_INFO;
		cmd_addr = 8'h00;
		cmd_data = 16'h0000;
		stall = 1'b0;
		pos_valid = 1'b0;
		pos_in = 20'h00000;
		main_low = 1'b0;
		motion = 1'b0;
		trim = 16'h3C5A;
		n_mismatch = 0;
		comparisons = 0;
		corr = -(longint'(3375) * 1048576) / 1296000;
		cyc(8);
		rst_n = 1'b1;
		load_def = 1'b1;
		cyc(1);
		load_def = 1'b0;
		cyc(4);
		ld(CMD_LOAD_BYTE, {1'b0, PAGE_SEL_ADDR}, 16'h0000);
		for (int a = 8'h12; a <= 8'h21; a++) ld(CMD_LOAD_WORD, 8'(a), COEF_DEFAULT);
		for (int a = 8'h80; a <= 8'h8F; a++) ld(CMD_LOAD_WORD, 8'(a), BIN_DEFAULT);
		ld(CMD_LOAD_WORD, CFG_WAKE, WAKE_DEFAULT);
		st(CMD_STORE_WORD, 8'h22, 16'h1234);
		ld(CMD_LOAD_WORD, 8'h22, 16'h0000);
		st(CMD_STORE_WORD, CFG_COEF_LO, 16'hBEEF);
		st(CMD_STORE_WORD, CFG_COEF_HI, 16'h0102);
		ld(CMD_LOAD_WORD, CFG_COEF_LO, 16'hBEEF);
		ld(CMD_LOAD_WORD, CFG_COEF_HI, 16'h0102);
		st(CMD_STORE_BYTE, 8'h7E, 16'h005A);
		ld(CMD_LOAD_BYTE, 8'h7E, 16'h005A);
		// capture is refused outside validation mode, then runs and is read back
		st(CMD_STORE_BYTE, {1'b0, PAGE_SEL_ADDR}, 16'h0007);
		ld(CMD_LOAD_BYTE, {1'b0, PAGE_SEL_ADDR}, 16'h0007);
		st(CMD_STORE_BYTE, {1'b0, VALID_MODE_ADDR}, 16'h0000);
		cmd(CMD_CAPTURE, 8'h00, 16'h0000);
		rsp("capture refused", ACK_REFUSED);
		st(CMD_STORE_BYTE, {1'b0, VALID_MODE_ADDR}, 16'h0001);
		cmd(CMD_CAPTURE, 8'h00, 16'h0000);
		rsp("capture ack", ACK_OK);
		chk("capture busy", 20'h1, 20'(busy));
		for (int t = 0; t < 4000 && busy !== 1'b0; t++) cyc(1);
		chk("capture done", 20'h0, 20'(busy));
		for (int k = 0; k < 800; k += 399) begin
			cmd(CMD_FETCH, 8'h00, 16'(k));
			rsp("fetch index", 16'(k));
			rsp("fetch sample", 16'(k) ^ 16'hA5A5);
		end
		// three info replies overfill the 8-word buffer while the master stalls
		stall = 1'b1;
		// an edge passes between requests so valid never drops and rises in one step
		repeat (3) begin
			cmd(CMD_INFO, 8'h00, 16'h0000);
			cyc(1);
		end
		cyc(10);
		chk("ready when full", 20'h0, 20'(cmd_ready));
		chk("words passed", 20'h0, 20'(u_ecm_master_model.q.size()));
		stall = 1'b0;
		repeat (3) begin
			rsp("encoder type", ENC_TYPE);
			rsp("firmware version", FW_VERSION);
			rsp("trim code", trim);
		end
		// bin corrections: zero, negative and wrapping
		st(CMD_STORE_WORD, 8'(CFG_BIN_LO + 8'h03), 16'(corr));
		st(CMD_STORE_WORD, CFG_BIN_HI, 16'h0010);
		pos(20'h01234, 20'h01234);
		pos(20'h30005, 20'(longint'(20'h30005) + corr));
		pos(20'hFFFF8, 20'h00008);
		pos_valid = 1'b0;
		// battery mode with default and changed idle period
		main_low = 1'b1;
		cyc(6);
		chk("battery mode", 20'h1, 20'(batt));
		chk("ready in battery", 20'h0, 20'(cmd_ready));
		gap("idle wake", 21 * MSC);
		motion = 1'b1;
		gap("moving wake", FAST_WAKE_MS * MSC);
		motion = 1'b0;
		main_low = 1'b0;
		cyc(6);
		chk("ready after battery", 20'h1, 20'(cmd_ready));
		st(CMD_STORE_WORD, CFG_WAKE, 16'h0005);
		main_low = 1'b1;
		gap("set idle wake", 5 * MSC);
		main_low = 1'b0;
		cyc(6);
		// second reset: page returns to 0, words survive
		rst_n = 1'b0;
		cyc(8);
		rst_n = 1'b1;
		cyc(4);
		ld(CMD_LOAD_BYTE, {1'b0, PAGE_SEL_ADDR}, 16'h0000);
		ld(CMD_LOAD_WORD, CFG_COEF_LO, 16'hBEEF);
		ld(CMD_LOAD_WORD, CFG_BIN_HI, 16'h0010);
		test_done();
	end
endmodule
